// *** pkg/fsp_pkg.sv ***
/*
 * fsp_pkg: constants for the flash self-program controller.
 * assumes word-addressed flash, page address in the upper bits of the pointer.
 */
package fsp_pkg;
	localparam int ADDR_W = 12;
	localparam int PAGE_W = 5;
	// area split: pages at or above this are in the blocking area
	localparam logic [ADDR_W-1:0] BLOCKING_BASE = 12'h0C00;
	// loader size by fuse code, in words, all inside the blocking area
	localparam logic [ADDR_W-1:0] LOADER_SIZE_0 = 12'h0400;
	localparam logic [ADDR_W-1:0] LOADER_SIZE_1 = 12'h0200;
	localparam logic [ADDR_W-1:0] LOADER_SIZE_2 = 12'h0100;
	localparam logic [ADDR_W-1:0] LOADER_SIZE_3 = 12'h0080;
	localparam logic [ADDR_W-1:0] FLASH_TOP = 12'hFFF;
	// lock pair encodings
	localparam logic [1:0] LOCK_NONE = 2'h3;
	localparam logic [1:0] LOCK_WR = 2'h2;
	localparam logic [1:0] LOCK_WR_RD = 2'h0;
	localparam logic [1:0] LOCK_RD = 2'h1;
	localparam logic [1:0] LOCK_RESET = 2'h3;
	// program time in ns, and in cycles of the clock
	localparam int PROG_TIME_NS = 4000;
	localparam int CLK_NS = 20;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_NS;
	localparam int CNT_W = 16;
	typedef enum logic [2:0]
	{
		FSP_IDLE = 3'b001,
		FSP_PROG_CONC = 3'b010,
		FSP_PROG_BLOCK = 3'b100
	} fsp_state_e;
endpackage

// *** rtl/fsp_timer.sv ***
/*
 * fsp_timer: counts down one programming operation.
 * assumes start is a single-cycle pulse on clk.
 */
`timescale 1ns/1ns
module fsp_timer #(
	parameter int COUNT = fsp_pkg::PROG_CYCLES
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic start,
	output logic      done
);
	logic [fsp_pkg::CNT_W-1:0] cnt_q;
	logic [fsp_pkg::CNT_W-1:0] cnt_d;
	logic                      run_q;
	wire last = run_q && (cnt_q == '0);

	assign cnt_d = start ? fsp_pkg::CNT_W'(COUNT - 1) : (run_q ? cnt_q - 1'b1 : cnt_q);
	assign done = last;

	// run flag drops on the final count
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			run_q <= start | (run_q & ~last);
		end
	end
endmodule

// *** rtl/fsp_ctrl.sv ***
/*
 * fsp_ctrl: decides when a self-program store may run, stalls the core
 * for blocking-area targets, keeps the concurrent-area busy flag.
 * assumes core on the same clock and reset; fuses and locks steady inputs.
 */
`timescale 1ns/1ns
module fsp_ctrl #(
	parameter int ADDR_W = fsp_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [1:0]        loader_size_fuses,
	input  wire logic [ADDR_W-1:0] exec_pc,
	input  wire logic [ADDR_W-1:0] addr_ptr,
	input  wire logic              self_program_store_op,
	input  wire logic              busy_clear,
	input  wire logic              lock_set,
	input  wire logic [3:0]        lock_set_val,
	input  wire logic              chip_erase,
	input  wire logic              load_req,
	input  wire logic [ADDR_W-1:0] load_addr,
	output logic                   load_allowed,
	output logic                   core_halt,
	output logic                   prog_active,
	output logic [ADDR_W-1:0]      prog_addr,
	output logic                   concurrent_area_busy,
	output logic                   store_rejected,
	output logic                   app_lock_high,
	output logic                   app_lock_low,
	output logic                   loader_lock_high,
	output logic                   loader_lock_low
);
	fsp_pkg::fsp_state_e state_q;
	fsp_pkg::fsp_state_e state_d;
	logic [ADDR_W-1:0]   addr_q;
	logic                busy_q;
	logic [1:0]          app_lock_q;
	logic [1:0]          ldr_lock_q;
	logic                done;

	// loader base from fuses; loader sits at the top of flash
	logic [ADDR_W-1:0] ldr_size;
	always_comb
	begin
		unique case (loader_size_fuses)
			2'h0: ldr_size = fsp_pkg::LOADER_SIZE_0;
			2'h1: ldr_size = fsp_pkg::LOADER_SIZE_1;
			2'h2: ldr_size = fsp_pkg::LOADER_SIZE_2;
			2'h3: ldr_size = fsp_pkg::LOADER_SIZE_3;
		endcase
	end
	wire [ADDR_W-1:0] ldr_base = fsp_pkg::FLASH_TOP - ldr_size + 1'b1;

	wire pc_in_loader  = exec_pc >= ldr_base;
	wire tgt_in_loader = addr_ptr >= ldr_base;
	wire tgt_blocking  = addr_ptr >= fsp_pkg::BLOCKING_BASE;
	wire idle          = state_q == fsp_pkg::FSP_IDLE;

	// write protection per section; 10 and 00 both forbid writes
	wire app_wr_ok = app_lock_q[0];
	wire ldr_wr_ok = ldr_lock_q[0];
	wire wr_ok     = tgt_in_loader ? ldr_wr_ok : app_wr_ok;
	// any page may be targeted from the loader while idle, subject only to locks
	wire start     = idle && self_program_store_op && pc_in_loader && wr_ok;
	assign store_rejected = self_program_store_op && !start;

	// cross-section loads: 00 and 01 forbid, i.e. high bit clear
	wire ld_tgt_ldr = load_addr >= ldr_base;
	wire ld_cross   = pc_in_loader != ld_tgt_ldr;
	wire ld_lock_hi = ld_tgt_ldr ? ldr_lock_q[1] : app_lock_q[1];
	assign load_allowed = load_req && !(ld_cross && !ld_lock_hi);

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			fsp_pkg::FSP_IDLE:
				if (start)
					state_d = tgt_blocking ? fsp_pkg::FSP_PROG_BLOCK : fsp_pkg::FSP_PROG_CONC;
			fsp_pkg::FSP_PROG_CONC,
			fsp_pkg::FSP_PROG_BLOCK:
				if (done)
					state_d = fsp_pkg::FSP_IDLE;
			default: state_d = fsp_pkg::FSP_IDLE;
		endcase
	end

	fsp_timer #(
		.COUNT(fsp_pkg::PROG_CYCLES)
	) u_timer (
		.clk    (clk),
		.reset_n(reset_n),
		.start  (start),
		.done   (done)
	);

	// halt only for blocking-area targets; concurrent ones keep core running
	assign core_halt   = state_q == fsp_pkg::FSP_PROG_BLOCK;
	assign prog_active = !idle;
	assign prog_addr   = addr_q;
	assign concurrent_area_busy = busy_q;
	assign app_lock_high    = app_lock_q[1];
	assign app_lock_low     = app_lock_q[0];
	assign loader_lock_high = ldr_lock_q[1];
	assign loader_lock_low  = ldr_lock_q[0];

	wire busy_set = start && !tgt_blocking;

	// length of the current halt, so the whole-operation stall is checked
	// against a counter rather than an open-ended repetition
	logic [fsp_pkg::CNT_W-1:0] halt_len_q;
	logic [fsp_pkg::CNT_W-1:0] halt_len_d;
	assign halt_len_d = core_halt ? halt_len_q + 1'b1 : '0;
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			halt_len_q <= '0;
		else
			halt_len_q <= halt_len_d;
	end

	// set beats clear; clear ignored while the area is still being programmed
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			state_q <= fsp_pkg::FSP_IDLE;
			addr_q  <= '0;
			busy_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			if (start)
				addr_q <= addr_ptr;
			if (busy_set)
				busy_q <= 1'b1;
			else if (busy_clear && state_q != fsp_pkg::FSP_PROG_CONC)
				busy_q <= 1'b0;
		end
	end

	// locks only move toward programmed (zero); erase restores them
	always_ff @(posedge clk)
	begin
		if (!reset_n || chip_erase)
		begin
			app_lock_q <= fsp_pkg::LOCK_RESET;
			ldr_lock_q <= fsp_pkg::LOCK_RESET;
		end
		else if (lock_set)
		begin
			app_lock_q <= app_lock_q & lock_set_val[1:0];
			ldr_lock_q <= ldr_lock_q & lock_set_val[3:2];
		end
	end

	busy_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == fsp_pkg::FSP_PROG_CONC) |-> concurrent_area_busy)
		else $error("busy flag low during concurrent programming");
	conc_nohalt_a: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == fsp_pkg::FSP_PROG_CONC) |-> !core_halt)
		else $error("core halted for concurrent target");
	block_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
		(start && tgt_blocking) |=> core_halt)
		else $error("halt missing after blocking-area start");
	app_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		(self_program_store_op && !pc_in_loader && idle) |=> $stable(state_q))
		else $error("store from application started programming");
	addr_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
		start |=> (prog_addr == $past(addr_ptr)) ##1 $stable(prog_addr))
		else $error("target address not held");
	busy_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
		(busy_q && !busy_clear) |=> busy_q)
		else $error("busy flag dropped without clear");
	lock_mono_a: assert property (@(posedge clk) disable iff (!reset_n)
		!chip_erase |=> (({app_lock_q, ldr_lock_q} & ~$past({app_lock_q, ldr_lock_q})) == 4'h0))
		else $error("lock bit cleared without erase");
	wr_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
		(self_program_store_op && !tgt_in_loader && !app_lock_q[0]) |-> !start)
		else $error("write into locked application section");
	ldr_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
		(self_program_store_op && tgt_in_loader && !ldr_lock_q[0]) |-> !start)
		else $error("write into locked loader section");

	// halt must last exactly one programming time, counted, not unrolled
	// a short halt would let the core fetch from a page being rewritten
	halt_len_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(core_halt) |-> (halt_len_q == fsp_pkg::CNT_W'(fsp_pkg::PROG_CYCLES)))
		else $error("halt length differs from programming time");
	halt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(core_halt && !done) |=> core_halt)
		else $error("halt released before timer done");
	ldr_inside_a: assert property (@(posedge clk) disable iff (!reset_n)
		ldr_base >= fsp_pkg::BLOCKING_BASE)
		else $error("loader base below blocking area");
	app_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		(load_req && pc_in_loader && !ld_tgt_ldr && !app_lock_q[1]) |-> !load_allowed)
		else $error("loader read of locked application section");
	ldr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		(load_req && !pc_in_loader && ld_tgt_ldr && !ldr_lock_q[1]) |-> !load_allowed)
		else $error("application read of locked loader section");
	busy_set_a: assert property (@(posedge clk) disable iff (!reset_n)
		busy_set |=> concurrent_area_busy)
		else $error("busy flag not set at concurrent start");
endmodule

// *** sim/fsp_core_model.sv ***
/* fsp_core_model: processor core fetch model facing the controller.
   assumes the same clk and reset_n as the controller. */
`timescale 1ns/1ns
module fsp_core_model (
	input  wire logic   clk,
	input  wire logic   reset_n,
	input  wire logic   core_halt,
	input  wire logic   concurrent_area_busy,
	output logic [11:0] fetch_pc,
	output int          fetch_count
);
	// a halted core holds its fetch; while busy it keeps out of the concurrent area
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			fetch_count <= 0;
			fetch_pc <= 12'h000;
		end
		else if (!core_halt)
		begin
			fetch_count <= fetch_count + 1;
			fetch_pc <= concurrent_area_busy ? fsp_pkg::BLOCKING_BASE : fetch_pc + 12'h001;
		end
	end
endmodule

// *** sim/fsp_ctrl_test.sv ***
/* fsp_ctrl_test: scenario bench for the self-program controller.
   assumes inputs change 2 ns after each rising edge. */
`timescale 1ns/1ns
module fsp_ctrl_test;
	logic        clk = 0, reset_n = 0, sp = 0, bc = 0, ls = 0, ce = 0, lr = 0, r;
	logic [1:0]  fz = 2'h0;
	logic [3:0]  lv = 4'h0;
	logic [11:0] pc = 12'h000, ap = 12'h000, la = 12'h000, pa, b, fpc;
	logic        la_ok, halt, act, busy, rej, alh, alw, llh, llw;
	logic [11:0] sz[4] = '{fsp_pkg::LOADER_SIZE_0, fsp_pkg::LOADER_SIZE_1,
		fsp_pkg::LOADER_SIZE_2, fsp_pkg::LOADER_SIZE_3};
	int          fail_count = 0, cmp_count = 0, fc, fcnt, n;
	fsp_ctrl fsp_ctrl_i (.clk(clk), .reset_n(reset_n), .loader_size_fuses(fz), .exec_pc(pc),
		.addr_ptr(ap), .self_program_store_op(sp), .busy_clear(bc), .lock_set(ls),
		.lock_set_val(lv), .chip_erase(ce), .load_req(lr), .load_addr(la),
		.load_allowed(la_ok), .core_halt(halt), .prog_active(act), .prog_addr(pa),
		.concurrent_area_busy(busy), .store_rejected(rej), .app_lock_high(alh),
		.app_lock_low(alw), .loader_lock_high(llh), .loader_lock_low(llw));
	fsp_core_model fsp_core_model_i (.clk(clk), .reset_n(reset_n), .core_halt(halt),
		.concurrent_area_busy(busy), .fetch_pc(fpc), .fetch_count(fcnt));
	initial
		forever #10 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic step(int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
	endtask
	// rejection is a same-cycle pulse, so it is caught before the taking edge
	task automatic store(logic [11:0] p, logic [11:0] a);
		pc = p;
		ap = a;
		sp = 1;
		#1 r = rej;
		step(1);
		sp = 0;
	endtask
	task automatic wait_idle();
		n = 0;
		while (act === 1'b1 && n < 300)
		begin
			step(1);
			n++;
		end
		if (n >= 300)
		begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic t_basic();
		chk("reset state", {halt, busy, act, alh, alw, llh, llw, pa}, 19'h0_F000);
		store(12'h100, 12'h200);
		chk("app store rejected", {r, act}, 2'h2);
		step(1);
		store(12'hC00, 12'h123);
		chk("conc start", {act, busy, halt, pa}, 15'h6123);
		fc = fcnt;
		ap = 12'h456;
		pulse(bc);
		wait_idle();
		chk("latched addr", pa, 12'h123);
		chk("fetches run", fcnt - fc, fsp_pkg::PROG_CYCLES);
		chk("busy held", busy, 1'b1);
		store(12'hC00, 12'h000);
		chk("store while busy", {r, act, busy, pa}, 15'h3000);
		wait_idle();
		chk("fetch stays out", fpc, fsp_pkg::BLOCKING_BASE);
		pulse(bc);
		chk("busy cleared", busy, 1'b0);
		store(12'hC00, 12'hF80);
		chk("loader self target", {halt, busy}, 2'h2);
		fc = fcnt;
		wait_idle();
		chk("halt length", n, fsp_pkg::PROG_CYCLES);
		chk("core frozen", fcnt - fc, 0);
		$display("t_basic done");
	endtask
	task automatic t_fuse();
		for (int f = 0; f < 4; f++)
		begin
			fz = 2'(f);
			b = -sz[f];
			store(b - 12'h001, 12'hFC0);
			chk("below loader", r, 1'b1);
			step(1);
			store(b, 12'hFC0);
			chk("loader base", {r, halt}, 2'h1);
			wait_idle();
		end
		$display("t_fuse done");
	endtask
	task automatic t_lock();
		fz = 2'h0;
		pc = 12'hC00;
		lr = 1;
		la = 12'h100;
		lv = 4'hE;
		pulse(ls);
		chk("app write lock", {alh, alw, llh, llw, la_ok}, 5'h17);
		store(12'hC00, 12'h100);
		chk("app write refused", r, 1'b1);
		lv = 4'h4;
		pulse(ls);
		chk("both pairs", {alh, alw, llh, llw, la_ok}, 5'h02);
		pc = 12'h100;
		la = 12'hF00;
		step(1);
		chk("loader read lock", la_ok, 1'b0);
		lv = 4'hF;
		pulse(ls);
		chk("no clear by set", {alh, alw, llh, llw}, 4'h1);
		lv = 4'h3;
		pulse(ls);
		store(12'hFC0, 12'hF80);
		chk("loader write refused", {r, llh, llw}, 3'h4);
		pulse(ce);
		chk("chip erase", {alh, alw, llh, llw, la_ok}, 5'h1F);
		lr = 0;
		$display("t_lock done");
	endtask
	initial
	begin
		step(6);
		reset_n = 1;
		t_basic();
		t_fuse();
		t_lock();
		report_and_stop();
	end
endmodule
